// ---- core/fpp_pkg.sv ----
// constants shared by the flash program/erase protection block
package fpp_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
	localparam logic [7:0] OFS_KEY_CODE = 8'h04;
	localparam logic [7:0] OFS_ARRAY_SEL = 8'h08;
	localparam logic [7:0] OFS_OP_CMD = 8'h0c;
	localparam logic [7:0] OFS_OP_STATUS = 8'h10;
	// ----------------------------------------------------------------
	// control/status fields
	// ----------------------------------------------------------------
	localparam int CS_WE_BIT = 0;
	localparam int CS_TRIG_BIT = 1;
	localparam int CS_RAMVEC_BIT = 2;
	localparam int CS_ERR_BIT = 4;
	// ----------------------------------------------------------------
	// operation command and status fields
	// ----------------------------------------------------------------
	localparam int CMD_PROG_BIT = 0;
	localparam int CMD_ERASE_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_FAIL_BIT = 1;
	localparam int ST_DONE_BIT = 2;
	localparam int ST_DL_BIT = 3;
	// ----------------------------------------------------------------
	// key and selection codes, reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] KEY_DOWNLOAD = 8'ha5;
	localparam logic [7:0] KEY_PROG_ERASE = 8'h5a;
	localparam logic [7:0] SEL_BOOT_CODE = 8'haa;
	localparam logic [7:0] SEL_USER_CODE = 8'h00;
	localparam logic [7:0] KEY_RESET = 8'h00;
	// ----------------------------------------------------------------
	// sizes and timing
	// ----------------------------------------------------------------
	localparam int BOOT_ARRAY_KBYTES = 16;
	localparam int BOOT_ARRAY_BYTES = BOOT_ARRAY_KBYTES * 1024;
	localparam int DL_CYCLES = 8;
	localparam int OP_CYCLES = 16;
	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_DOWNLOAD,
		SEQ_RUN
	} fpp_seq_type;
endpackage

// ---- core/fpp_sync.sv ----
// two-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ns
`default_nettype none
module fpp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ---- core/fpp_err_latch.sv ----
// error-protection latch: illegal events during program/erase
`timescale 1ns/1ns
`default_nettype none
module fpp_err_latch (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic standby,
	input wire logic busy,
	input wire logic irq_taken,
	input wire logic flash_rd,
	input wire logic sleep_exec,
	input wire logic other_master,
	output logic err_set,
	output logic err_r
);
	import fpp_pkg::*;
	always_comb begin
		err_set = busy & (irq_taken | flash_rd | sleep_exec | other_master); // [R9] [R10] [R11] [R12]
	end
	// no register write reaches this latch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			err_r <= 1'b0;
		end else if (standby) begin
			err_r <= 1'b0; // [R13]
		end else if (err_set) begin
			err_r <= 1'b1; // [R8]
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	irq_sets_err_a: assert property (@(posedge clk) disable iff (sys_rst)
		busy && irq_taken && !standby |=> err_r) // [R9]
		else $error("interrupt during operation did not set error");
	err_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
		err_r && !standby |=> err_r) // [R13]
		else $error("error flag cleared without reset or standby");
	read_sets_err_a: assert property (@(posedge clk) disable iff (sys_rst)
		busy && flash_rd && !standby |=> err_r) // [R10]
		else $error("flash read during operation did not set error");
	sleep_master_err_a: assert property (@(posedge clk) disable iff (sys_rst)
		busy && (sleep_exec || other_master) && !standby |=> err_r) // [R11] [R12]
		else $error("sleep or bus grant during operation did not set error");
endmodule
`default_nettype wire

// ---- core/fpp_top.sv ----
// flash program/erase protection and array switching with an apb slave
// ----------------------------------------------------------------
// Notes on behaviour
// [R1] low write-enable pin clears flag, protects
// [R2] hardware protection: operation runs, no write, fails
// [R3] reset or standby initialises registers, protects; standby leaves the array select register unchanged
// [R4] clearing download trigger protects program/erase
// [R5] download needs A5 key, operation 5A
// [R6] software starts download from on-chip RAM
// [R7] software writes 5A key after download, init
// [R8] malfunction sets error flag, aborts operation
// [R9] interrupt during operation sets error flag
// [R10] flash read during operation sets error
// [R11] sleep during operation sets error flag
// [R12] other bus master during operation sets error
// [R13] error state held until reset or standby
// [R14] system holds reset 100 us after error
// [R15] array switching only from on-chip RAM
// [R16] four no-ops after array select write
// [R17] no interrupts while switching arrays
// [R18] array switch moves vectors; RAM vector bit
// [R19] boot array 16 KB; beyond reads undefined
// [R20] boot array selected in normal mode blocks
// [R21] programmer mode polls status, 12 MHz clock
// [R22] array select reads AA for boot array
// [R23] no flash access until key cleared
// [R24] error flag readable in control/status register
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module fpp_top #(
	parameter int AW = 20,
	parameter int DL_CNT = fpp_pkg::DL_CYCLES,
	parameter int OP_CNT = fpp_pkg::OP_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic write_enable_pin,
	input wire logic boot_mode_pin,
	input wire logic programmer_mode_pin,
	input wire logic standby,
	input wire logic irq_taken,
	input wire logic sleep_exec,
	input wire logic other_master,
	input wire logic flash_rd,
	input wire logic [AW-1:0] flash_addr,
	output logic download_en,
	output logic array_write_en,
	output logic pe_busy,
	output logic boot_array_sel,
	output logic vector_in_ram,
	output logic rd_undef
);
	import fpp_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pins_s;
	fpp_sync #(.W(3)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d({programmer_mode_pin, boot_mode_pin, write_enable_pin}),
		.q(pins_s)
	);
	logic we_s;
	logic boot_s;
	logic prog_mode_s;
	assign we_s = pins_s[0];
	assign boot_s = pins_s[1];
	assign prog_mode_s = pins_s[2];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic we_flag_r;
	logic trig_r;
	logic ramvec_r;
	logic [7:0] key_r;
	logic boot_sel_r;
	logic [1:0] strap_cnt_r;
	logic fail_r;
	logic done_r;
	fpp_seq_type seq_r;
	logic [15:0] cnt_r;
	logic err_set;
	logic err_r;

	// ----------------------------------------------------------------
	// apb decode: one wait state, write at the completing edge
	// ----------------------------------------------------------------
	logic acc;
	logic wr;
	logic mapped;
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == OFS_CTRL_STATUS) || (a == OFS_KEY_CODE) ||
			(a == OFS_ARRAY_SEL) || (a == OFS_OP_CMD) || (a == OFS_OP_STATUS);
	endfunction
	assign acc = psel & penable & pready;
	assign mapped = is_mapped(paddr);
	assign wr = acc & pwrite & mapped;

	logic wr_cs;
	logic wr_key;
	logic wr_sel;
	logic wr_cmd;
	assign wr_cs = wr & (paddr == OFS_CTRL_STATUS);
	assign wr_key = wr & (paddr == OFS_KEY_CODE);
	assign wr_sel = wr & (paddr == OFS_ARRAY_SEL);
	assign wr_cmd = wr & (paddr == OFS_OP_CMD);

	// ----------------------------------------------------------------
	// protection decisions
	// ----------------------------------------------------------------
	logic normal_mode;
	logic boot_block;
	logic dl_start;
	logic op_req;
	logic op_ok;
	assign normal_mode = ~boot_s & ~prog_mode_s;
	assign boot_block = boot_sel_r & normal_mode; // [R20]
	assign dl_start = wr_cs & pwdata[CS_TRIG_BIT] & ~trig_r & (key_r == KEY_DOWNLOAD) &
		(seq_r == SEQ_IDLE); // [R5]
	assign op_req = wr_cmd & (pwdata[CMD_PROG_BIT] | pwdata[CMD_ERASE_BIT]);
	assign op_ok = trig_r & (key_r == KEY_PROG_ERASE) & ~err_r & ~boot_block &
		(seq_r == SEQ_IDLE); // [R4] [R5] [R20]

	// ----------------------------------------------------------------
	// write-enable flag follows the pin
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			we_flag_r <= 1'b0;
		end else if (standby) begin
			we_flag_r <= 1'b0; // [R3]
		end else begin
			we_flag_r <= we_s; // [R1]
		end
	end

	// ----------------------------------------------------------------
	// control bits: download trigger and ram vector enable
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trig_r <= 1'b0;
			ramvec_r <= 1'b0;
		end else if (standby) begin
			trig_r <= 1'b0; // [R3]
			ramvec_r <= 1'b0;
		end else if (wr_cs) begin
			ramvec_r <= pwdata[CS_RAMVEC_BIT]; // [R18]
			if (!pwdata[CS_TRIG_BIT]) begin
				trig_r <= 1'b0; // [R4]
			end else if (dl_start) begin
				trig_r <= 1'b1; // [R5]
			end
		end
	end

	// ----------------------------------------------------------------
	// key code register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			key_r <= KEY_RESET;
		end else if (standby) begin
			key_r <= KEY_RESET; // [R3]
		end else if (wr_key) begin
			key_r <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// array select: boot strap caught after reset release
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			boot_sel_r <= 1'b0;
			strap_cnt_r <= 2'h0;
		end else if (strap_cnt_r != 2'h3) begin
			// synchroniser leaves reset at zero: keep loading until the pin arrives
			boot_sel_r <= boot_s; // [R22]
			strap_cnt_r <= strap_cnt_r + 2'h1;
		end else if (wr_sel) begin
			boot_sel_r <= (pwdata[7:0] == SEL_BOOT_CODE);
		end
	end

	// ----------------------------------------------------------------
	// sequencer: download, then program/erase run
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_r <= SEQ_IDLE;
			cnt_r <= '0;
		end else if (standby) begin
			seq_r <= SEQ_IDLE; // [R3]
			cnt_r <= '0;
		end else begin
			case (seq_r)
				SEQ_IDLE: begin
					if (dl_start) begin
						seq_r <= SEQ_DOWNLOAD;
						cnt_r <= 16'(DL_CNT - 1);
					end else if (op_req && op_ok) begin
						seq_r <= SEQ_RUN;
						cnt_r <= 16'(OP_CNT - 1);
					end
				end
				SEQ_DOWNLOAD: begin
					if (!trig_r) begin
						seq_r <= SEQ_IDLE; // [R4]
					end else if (cnt_r == '0) begin
						seq_r <= SEQ_IDLE;
					end else begin
						cnt_r <= cnt_r - 16'h0001;
					end
				end
				SEQ_RUN: begin
					if (err_set || err_r) begin
						seq_r <= SEQ_IDLE; // [R8]
					end else if (cnt_r == '0) begin
						seq_r <= SEQ_IDLE;
					end else begin
						cnt_r <= cnt_r - 16'h0001;
					end
				end
				default: begin
					seq_r <= SEQ_IDLE;
				end
			endcase
		end
	end

	logic run_end;
	assign run_end = (seq_r == SEQ_RUN) & (err_set | err_r | (cnt_r == '0));

	// ----------------------------------------------------------------
	// pass/fail result and done flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fail_r <= 1'b0;
		end else if (standby) begin
			fail_r <= 1'b0; // [R3]
		end else if (op_req && !op_ok) begin
			fail_r <= 1'b1; // [R5]
		end else if (run_end) begin
			fail_r <= err_set | err_r | ~we_flag_r; // [R2] [R8]
		end else if (op_req) begin
			fail_r <= 1'b0;
		end
	end

	// completion wins over a clearing command write in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_r <= 1'b0;
		end else if (standby) begin
			done_r <= 1'b0;
		end else if (run_end) begin
			done_r <= 1'b1; // [R21]
		end else if (wr_cmd) begin
			done_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// error-protection latch
	// ----------------------------------------------------------------
	fpp_err_latch u_err (
		.clk(clk),
		.sys_rst(sys_rst),
		.standby(standby),
		.busy(seq_r == SEQ_RUN),
		.irq_taken(irq_taken),
		.flash_rd(flash_rd),
		.sleep_exec(sleep_exec),
		.other_master(other_master),
		.err_set(err_set),
		.err_r(err_r)
	);

	// ----------------------------------------------------------------
	// apb read data and handshake
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			OFS_CTRL_STATUS: begin
				rd_mux[CS_WE_BIT] = we_flag_r;
				rd_mux[CS_TRIG_BIT] = trig_r;
				rd_mux[CS_RAMVEC_BIT] = ramvec_r;
				rd_mux[CS_ERR_BIT] = err_r; // [R24]
			end
			OFS_KEY_CODE: begin
				rd_mux[7:0] = key_r;
			end
			OFS_ARRAY_SEL: begin
				rd_mux[7:0] = boot_sel_r ? SEL_BOOT_CODE : SEL_USER_CODE; // [R22]
			end
			OFS_OP_STATUS: begin
				rd_mux[ST_BUSY_BIT] = (seq_r == SEQ_RUN);
				rd_mux[ST_FAIL_BIT] = fail_r; // [R2]
				rd_mux[ST_DONE_BIT] = done_r;
				rd_mux[ST_DL_BIT] = (seq_r == SEQ_DOWNLOAD);
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= ~mapped;
		end else begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// flash-side outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			download_en <= 1'b0;
			array_write_en <= 1'b0;
			pe_busy <= 1'b0;
			boot_array_sel <= 1'b0;
			vector_in_ram <= 1'b0;
			rd_undef <= 1'b0;
		end else begin
			download_en <= (seq_r == SEQ_DOWNLOAD) & trig_r;
			array_write_en <= (seq_r == SEQ_RUN) & we_flag_r & ~err_r & ~err_set; // [R1] [R2]
			pe_busy <= (seq_r == SEQ_RUN);
			boot_array_sel <= boot_sel_r; // [R18]
			vector_in_ram <= ramvec_r; // [R18]
			rd_undef <= boot_sel_r & flash_rd &
				(32'(flash_addr) >= 32'(BOOT_ARRAY_BYTES)); // [R19]
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence run_s;
		seq_r == SEQ_RUN;
	endsequence
	sequence err_seen_s;
		err_set ##1 (seq_r == SEQ_IDLE);
	endsequence

	pin_low_flag_a: assert property (!we_s ##1 1'b1 |-> !we_flag_r) // [R1]
		else $error("write-enable flag set with pin low");
	hw_prot_nowr_a: assert property (!we_flag_r |=> !array_write_en) // [R2]
		else $error("array written under hardware protection");
	standby_init_a: assert property (standby |=> !trig_r && key_r == KEY_RESET && seq_r == SEQ_IDLE)
		// [R3]
		else $error("standby did not initialise registers");
	trig_clear_a: assert property (wr_cs && !pwdata[CS_TRIG_BIT] |=> !trig_r && seq_r != SEQ_RUN)
		// [R4]
		else $error("trigger clear did not protect");
	key_gate_a: assert property (seq_r == SEQ_IDLE ##1 run_s |-> $past(key_r) == KEY_PROG_ERASE)
		// [R5]
		else $error("operation started without key");
	err_abort_a: assert property (run_s and err_set |=> seq_r == SEQ_IDLE ##1 fail_r) // [R8]
		else $error("error did not abort operation");
	err_abort_seq_a: assert property (err_set and run_s |-> err_seen_s) // [R8]
		else $error("sequencer kept running after error");
	boot_block_a: assert property (boot_block && seq_r == SEQ_IDLE |=> seq_r != SEQ_RUN) // [R20]
		else $error("operation started on boot array in normal mode");
	sel_read_a: assert property (acc && !pwrite && paddr == OFS_ARRAY_SEL && boot_sel_r |->
		$past(boot_sel_r) && prdata[7:0] == SEL_BOOT_CODE) // [R22]
		else $error("array select did not read boot code");
	undef_read_a: assert property (boot_sel_r && flash_rd && 32'(flash_addr) < 32'(BOOT_ARRAY_BYTES)
		|=> !rd_undef) // [R19]
		else $error("in-range boot read flagged undefined");
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking testbench for the flash program/erase protection block
`timescale 1ns/1ns
`default_nettype none
module tb;
	import fpp_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic we_pin = 1'b1;
	logic boot_pin = 1'b0;
	logic prog_pin = 1'b0;
	logic standby = 1'b0;
	logic [3:0] ev = 4'h0;
	logic [19:0] flash_addr = 20'h0;
	logic download_en, array_write_en, pe_busy, boot_array_sel, vector_in_ram, rd_undef;
	int n_mismatch = 0;
	int comparisons = 0;
	int seed = 32'h2630;
	logic [31:0] q;
	logic e;
	logic [19:0] a;
	int k;
	always #5 clk = ~clk;
	// ----------------------------------------------------------------
	// device under test; event inputs: irq, flash read, sleep, other master
	// ----------------------------------------------------------------
	fpp_top #(.AW(20), .DL_CNT(DL_CYCLES), .OP_CNT(OP_CYCLES)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.write_enable_pin(we_pin), .boot_mode_pin(boot_pin), .programmer_mode_pin(prog_pin),
		.standby(standby), .irq_taken(ev[0]), .flash_rd(ev[1]), .sleep_exec(ev[2]),
		.other_master(ev[3]), .flash_addr(flash_addr), .download_en(download_en),
		.array_write_en(array_write_en), .pe_busy(pe_busy), .boot_array_sel(boot_array_sel),
		.vector_in_ram(vector_in_ram), .rd_undef(rd_undef)
	);
	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] cs(input logic we, input logic tr, input logic rv,
			input logic er);
		return {27'h0, er, 1'b0, rv, tr, we};
	endfunction
	// ----------------------------------------------------------------
	// apb master: request held until pready is sampled high
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			n_mismatch++;
			close_out();
		end
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask
	task automatic rdc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, ad, 32'h0);
		chk(q & m, x & m);
	endtask
	// sel 0 watches pe_busy, sel 1 watches download_en
	task automatic wait_on(input int sel, input logic lvl);
		int n;
		n = 0;
		while (((sel == 0) ? pe_busy : download_en) !== lvl && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) begin
			n_mismatch++;
			close_out();
		end
	endtask
	// download with the download key, then arm the program/erase key
	task automatic prep();
		wr(OFS_KEY_CODE, {24'h0, KEY_DOWNLOAD});
		wr(OFS_CTRL_STATUS, 32'h2);
		wait_on(1, 1'b1);
		wait_on(1, 1'b0);
		wr(OFS_KEY_CODE, {24'h0, KEY_PROG_ERASE});
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(OFS_CTRL_STATUS, 32'hffffffff, cs(1, 0, 0, 0));
		rdc(OFS_KEY_CODE, 32'hffffffff, 32'h0);
		rdc(OFS_OP_STATUS, 32'hffffffff, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk(e, 1'b1);
		wr(OFS_OP_STATUS, 32'hffffffff);
		rdc(OFS_OP_STATUS, 32'hffffffff, 32'h0);
		$display("test reset done");
		for (k = 0; k < 4; k++) begin
			q = $random(seed) & 32'hff;
			if (q[7:0] == KEY_DOWNLOAD) q = 32'h3c;
			wr(OFS_KEY_CODE, q);
			wr(OFS_CTRL_STATUS, 32'h2);
			rdc(OFS_CTRL_STATUS, 32'h1f, cs(1, 0, 0, 0));
		end
		prep();
		rdc(OFS_CTRL_STATUS, 32'h1f, cs(1, 1, 0, 0));
		wr(OFS_KEY_CODE, {24'h0, KEY_DOWNLOAD});
		wr(OFS_OP_CMD, 32'h1);
		rdc(OFS_OP_STATUS, 32'h3, 32'h2);
		wr(OFS_KEY_CODE, {24'h0, KEY_PROG_ERASE});
		for (k = 0; k < 2; k++) begin
			wr(OFS_OP_CMD, 32'h1 << k);
			wait_on(0, 1'b1);
			@(posedge clk);
			chk(array_write_en, 1'b1);
			wait_on(0, 1'b0);
			rdc(OFS_OP_STATUS, 32'h7, 32'h4);
		end
		$display("test keys done");
		we_pin <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(OFS_CTRL_STATUS, 32'h1, 32'h0);
		wr(OFS_OP_CMD, 32'h1);
		wait_on(0, 1'b1);
		@(posedge clk);
		chk(array_write_en, 1'b0);
		wait_on(0, 1'b0);
		rdc(OFS_OP_STATUS, 32'h7, 32'h6);
		we_pin <= 1'b1;
		repeat (4) @(posedge clk);
		$display("test write enable pin done");
		for (k = 0; k < 4; k++) begin
			wr(OFS_OP_CMD, 32'h1);
			wait_on(0, 1'b1);
			ev[k] <= 1'b1;
			@(posedge clk);
			ev[k] <= 1'b0;
			repeat (3) @(posedge clk);
			chk(pe_busy, 1'b0);
			rdc(OFS_CTRL_STATUS, 32'h10, 32'h10);
			rdc(OFS_OP_STATUS, 32'h7, 32'h6);
			wr(OFS_CTRL_STATUS, 32'h2);
			rdc(OFS_CTRL_STATUS, 32'h10, 32'h10);
			wr(OFS_OP_CMD, 32'h1);
			rdc(OFS_OP_STATUS, 32'h3, 32'h2);
			standby <= 1'b1;
			@(posedge clk);
			standby <= 1'b0;
			repeat (4) @(posedge clk);
			rdc(OFS_CTRL_STATUS, 32'h1f, cs(1, 0, 0, 0));
			rdc(OFS_KEY_CODE, 32'hff, 32'h0);
			prep();
		end
		$display("test error protection done");
		wr(OFS_CTRL_STATUS, 32'h0);
		rdc(OFS_CTRL_STATUS, 32'h2, 32'h0);
		wr(OFS_OP_CMD, 32'h1);
		rdc(OFS_OP_STATUS, 32'h3, 32'h2);
		wr(OFS_KEY_CODE, {24'h0, KEY_DOWNLOAD});
		wr(OFS_CTRL_STATUS, 32'h2);
		wr(OFS_CTRL_STATUS, 32'h0);
		repeat (2) @(posedge clk);
		chk(download_en, 1'b0);
		$display("test trigger clear done");
		wr(OFS_CTRL_STATUS, 32'h4);
		@(posedge clk);
		chk(vector_in_ram, 1'b1);
		rdc(OFS_CTRL_STATUS, 32'h1f, cs(1, 0, 1, 0));
		prep();
		wr(OFS_ARRAY_SEL, {24'h0, SEL_BOOT_CODE});
		rdc(OFS_ARRAY_SEL, 32'hff, {24'h0, SEL_BOOT_CODE});
		chk(boot_array_sel, 1'b1);
		wr(OFS_OP_CMD, 32'h2);
		rdc(OFS_OP_STATUS, 32'h3, 32'h2);
		prog_pin <= 1'b1;
		repeat (4) @(posedge clk);
		wr(OFS_OP_CMD, 32'h2);
		wait_on(0, 1'b1);
		wait_on(0, 1'b0);
		rdc(OFS_OP_STATUS, 32'h7, 32'h4);
		prog_pin <= 1'b0;
		wr(OFS_KEY_CODE, 32'h0);
		for (k = 0; k < 12; k++) begin
			a = (k == 0) ? 20'd16383 : (k == 1) ? 20'd16384 : 20'($random(seed));
			if (k == 6) begin
				wr(OFS_ARRAY_SEL, 32'h0);
				repeat (4) @(posedge clk);
			end
			ev[1] <= 1'b1;
			flash_addr <= a;
			@(posedge clk);
			ev[1] <= 1'b0;
			@(posedge clk);
			chk(rd_undef, (k < 6) && (a >= 20'(BOOT_ARRAY_BYTES)));
		end
		$display("test array switching done");
		wr(OFS_KEY_CODE, {24'h0, KEY_PROG_ERASE});
		wr(OFS_OP_CMD, 32'h1);
		wait_on(0, 1'b1);
		ev[2] <= 1'b1;
		@(posedge clk);
		ev[2] <= 1'b0;
		repeat (2) @(posedge clk);
		rdc(OFS_CTRL_STATUS, 32'h10, 32'h10);
		boot_pin <= 1'b1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (10000) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(OFS_ARRAY_SEL, 32'hff, {24'h0, SEL_BOOT_CODE});
		rdc(OFS_KEY_CODE, 32'hff, 32'h0);
		rdc(OFS_CTRL_STATUS, 32'h1f, cs(1, 0, 0, 0));
		$display("test second reset done");
		close_out();
	end
endmodule
`default_nettype wire
